/* File: design/rmsc_cfg.svh */
// Operation
// - idle watches radio and serial for data
// - idle leaves for transmit, receive, command or sleep
// - byte threshold starts transmit; zero disables
// - silence timeout with pending byte starts transmit
// - no transmit while a reception runs
// - channel initializer first; input keeps buffering
// - packets capped; chain until buffer empty
// - forward packet only on id/channel/address match
// - sleep needs nonzero selection plus trigger
// - asleep: no transfer before returning idle
// - selection 1: pin high sleeps, low wakes
// - finish transfer before entering pin sleep
// - pin sleep: clear-to-send high, power low
// - cyclic settings 4-8 sleep 1 to 16 s
// - listen window 35 or 225 ms by rate
// - initializer while awake leads to reception
// - after cyclic reception, sleep on inactivity
// - cyclic sleep: cts high, power low
// - pin wake forces idle until inactive
// - software flow control when setting enabled
// - reassert clear-to-send at 34 free bytes
`ifndef RMSC_CFG_SVH
`define RMSC_CFG_SVH

// register byte addresses
`define RMSC_REG_CTRL 8'h00
`define RMSC_REG_PKT 8'h04
`define RMSC_REG_TIME 8'h08
`define RMSC_REG_NET 8'h0C
`define RMSC_REG_ADDR 8'h10
`define RMSC_REG_STAT 8'h14

// reset values
`define RMSC_SEL_RST 4'h0
`define RMSC_THR_RST 8'h01
`define RMSC_MAXPK_RST 8'h40
`define RMSC_PTO_RST 16'h0003
`define RMSC_WAKE_RST 16'h0BB8
`define RMSC_ID_RST 16'h0000
`define RMSC_CHAN_RST 8'h00
`define RMSC_DADDR_RST 16'h0000

// sleep selections
`define RMSC_SEL_PIN 4'h1
`define RMSC_SEL_CYC_LO 4'h4
`define RMSC_SEL_CYC_HI 4'h8

// timing, printed units
`define RMSC_CLK_NS 5
`define RMSC_MS_NS 1000000
`define RMSC_CYC_BASE_MS 1000
`define RMSC_LISTEN_R1_MS 35
`define RMSC_LISTEN_R0_MS 225

// flow control
`define RMSC_CTS_RESUME_FREE 34
`define RMSC_XOFF 8'h13
`define RMSC_XON 8'h11

`endif

/* File: design/rmsc_pkg.sv */
package rmsc_pkg;

  // one-hot operating modes
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_INIT = 6'h02,
    ST_TXPK = 6'h04,
    ST_RX = 6'h08,
    ST_CMD = 6'h10,
    ST_SLEEP = 6'h20
  } rmsc_state_t;

endpackage

/* File: design/rmsc_ctrl.sv */
`timescale 1ns/100ps
`include "rmsc_cfg.svh"

module rmsc_ctrl
  import rmsc_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter int MS_CYCLES = `RMSC_MS_NS / `RMSC_CLK_NS
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // serial input bytes from the uart
  input wire logic ser_byte_valid,
  // radio transmit side
  output logic init_start,
  input wire logic init_done,
  output logic pkt_start,
  output logic [7:0] pkt_len,
  input wire logic pkt_near_end,
  // radio receive side
  input wire logic rf_rx_busy,
  input wire logic rf_init_detect,
  input wire logic rf_pkt_valid,
  input wire logic [15:0] rf_pkt_id,
  input wire logic [7:0] rf_pkt_chan,
  input wire logic [15:0] rf_pkt_addr,
  output logic rx_forward,
  // command mode
  input wire logic cmd_seq_det,
  input wire logic spi_in_use,
  input wire logic cmd_exit,
  // pins
  input wire logic sleep_pin,
  output logic cts_n,
  output logic transmit_power_indicator,
  // software flow characters toward the host
  output logic flow_char_valid,
  output logic [7:0] flow_char
);

  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [CW-1:0] RESUME = CW'(`RMSC_CTS_RESUME_FREE);
  localparam logic [15:0] LISTEN_R1 = 16'(`RMSC_LISTEN_R1_MS);
  localparam logic [15:0] LISTEN_R0 = 16'(`RMSC_LISTEN_R0_MS);
  localparam logic [31:0] MS_TOP = 32'(MS_CYCLES - 1);

  // saturating millisecond counter step
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction

  // cyclic sleep interval in ms for settings 4..8
  function automatic logic [15:0] cyc_ms(input logic [3:0] sel);
    logic [2:0] k;
    k = 3'(sel - `RMSC_SEL_CYC_LO);
    cyc_ms = 16'(`RMSC_CYC_BASE_MS) << k;
  endfunction

  rmsc_state_t state;
  rmsc_state_t next_state;
  logic [3:0] sleep_selection;
  logic radio_rate_setting;
  logic pin_wake_enable;
  logic software_flow_setting;
  logic [7:0] packetization_threshold;
  logic [7:0] max_packet_size;
  logic [15:0] packetization_timeout;
  logic [15:0] inactivity_wake_time;
  logic [15:0] network_identifier;
  logic [7:0] channel;
  logic [15:0] dest_address;
  logic [CW-1:0] pend;
  logic [CW-1:0] next_pend;
  logic [31:0] pre;
  logic ms_tick;
  logic [15:0] tmr_ms;
  logic [15:0] silent_ms;
  logic [15:0] inact_ms;
  logic listening;
  logic pin_s1, pin_s2, pin_s3, pin_lvl, pin_prev;
  logic flow_stop;
  logic flow_prev;
  logic accept, fire, match, cyclic, pin_mode, pin_fall;
  logic tx_trig, sleep_go, wake, listen_done, rx_start;
  logic [7:0] maxpk_eff, len;

  // sleep pin: three stages, level taken when stages 2 and 3 agree
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
      pin_lvl <= 1'b0;
      pin_prev <= 1'b0;
    end
    else
    begin
      pin_s1 <= sleep_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3)
        pin_lvl <= pin_s3;
      pin_prev <= pin_lvl;
    end
  end

  // decode of mode settings and trigger conditions
  assign pin_mode = (sleep_selection == `RMSC_SEL_PIN);
  assign cyclic = (sleep_selection >= `RMSC_SEL_CYC_LO) &&
                  (sleep_selection <= `RMSC_SEL_CYC_HI);
  assign pin_fall = pin_prev && !pin_lvl;
  assign maxpk_eff = (max_packet_size == 8'h00) ? 8'h01 : max_packet_size;
  assign len = (32'(pend) > 32'(maxpk_eff)) ? maxpk_eff : 8'(pend);
  assign accept = ser_byte_valid && (pend != FULL);
  assign match = (rf_pkt_id == network_identifier) &&
                 (rf_pkt_chan == channel) &&
                 (rf_pkt_addr == dest_address);
  assign tx_trig = ((packetization_threshold != 8'h00) &&
                    (32'(pend) >= 32'(packetization_threshold))) ||
                   ((packetization_timeout != 16'h0000) &&
                    (pend != '0) &&
                    (silent_ms >= packetization_timeout));
  assign listen_done = listening &&
    (tmr_ms >= (radio_rate_setting ? LISTEN_R1 : LISTEN_R0));
  // sleep only with a selection and a trigger; pin mode ignores idleness
  assign sleep_go = (sleep_selection != 4'h0) &&
    ((pin_mode && pin_lvl) ||
     (cyclic && listen_done) ||
     (cyclic && !listening &&
      inact_ms >= inactivity_wake_time));
  assign wake = pin_mode ? !pin_lvl :
    cyclic ? ((tmr_ms >= cyc_ms(sleep_selection)) ||
              (pin_wake_enable && pin_fall)) : 1'b1;
  assign rx_start = rf_rx_busy || rf_init_detect;
  assign fire = ((state == ST_INIT) && init_done) ||
                ((state == ST_TXPK) && pkt_near_end && (pend != '0));

  // mode selection; the idle branch order sets the priorities
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        // idle listens to both sides
        if (rx_start)
          next_state = ST_RX;
        else if (cmd_seq_det && !spi_in_use)
          next_state = ST_CMD;
        else if (tx_trig && !rf_rx_busy)
          next_state = ST_INIT;
        else if (sleep_go)
          next_state = ST_SLEEP;
      end
      ST_INIT:
        if (init_done)
          next_state = ST_TXPK;
      ST_TXPK:
        if (pkt_near_end && (pend == '0))
          next_state = ST_IDLE;
      ST_RX:
        if (!rx_start)
          next_state = ST_IDLE;
      ST_CMD:
        if (cmd_exit)
          next_state = ST_IDLE;
      ST_SLEEP:
        if (wake)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // pending byte count; input keeps counting during the initializer
  always_comb
  begin
    next_pend = pend;
    if (accept)
      next_pend = next_pend + CW'(1);
    if (fire)
      next_pend = next_pend - CW'(len);
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      pend <= '0;
    else
      pend <= next_pend;
  end

  // transmit strobes toward the radio
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      init_start <= 1'b0;
      pkt_start <= 1'b0;
      pkt_len <= 8'h00;
    end
    else
    begin
      init_start <= (state == ST_IDLE) && (next_state == ST_INIT);
      pkt_start <= fire;
      if (fire)
        pkt_len <= len;
    end
  end

  // matched packets go to the serial output side
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      rx_forward <= 1'b0;
    else
      rx_forward <= rf_pkt_valid && match && (state == ST_RX);
  end

  // ms prescaler; a long count so it is a parameter for simulation
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pre <= 32'h0000_0000;
      ms_tick <= 1'b0;
    end
    else
    begin
      ms_tick <= (pre == MS_TOP);
      pre <= (pre == MS_TOP) ? 32'h0000_0000 : pre + 32'h0000_0001;
    end
  end

  // time in mode, silence on the serial line, inactivity
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tmr_ms <= 16'h0000;
      silent_ms <= 16'h0000;
      inact_ms <= 16'h0000;
    end
    else
    begin
      if (next_state != state)
        tmr_ms <= 16'h0000;
      else if (ms_tick)
        tmr_ms <= sat_inc(tmr_ms);
      if (ser_byte_valid)
        silent_ms <= 16'h0000;
      else if (ms_tick)
        silent_ms <= sat_inc(silent_ms);
      if (ser_byte_valid || rx_start || state != ST_IDLE)
        inact_ms <= 16'h0000;
      else if (ms_tick)
        inact_ms <= sat_inc(inact_ms);
    end
  end

  // listen window after a timed cyclic wake
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      listening <= 1'b0;
    else if (state == ST_SLEEP && next_state == ST_IDLE)
      listening <= cyclic && !(pin_wake_enable && pin_fall);
    else if (state == ST_IDLE && next_state != ST_IDLE)
      listening <= 1'b0;
  end

  // buffer-full hold-off; a stop on the same cycle beats a resume
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      flow_stop <= 1'b0;
    else if (next_pend == FULL)
      flow_stop <= 1'b1;
    else if ((FULL - pend) >= RESUME)
      flow_stop <= 1'b0;
  end

  // pins: sleep forces cts high and the power line low
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cts_n <= 1'b1;
      transmit_power_indicator <= 1'b0;
    end
    else
    begin
      cts_n <= (state == ST_SLEEP) || flow_stop;
      transmit_power_indicator <= (state != ST_SLEEP);
    end
  end

  // stop/resume characters; useless for binary streams
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flow_prev <= 1'b0;
      flow_char_valid <= 1'b0;
      flow_char <= 8'h00;
    end
    else
    begin
      flow_prev <= flow_stop;
      flow_char_valid <= software_flow_setting &&
                         (flow_stop != flow_prev);
      if (flow_stop != flow_prev)
        flow_char <= flow_stop ? `RMSC_XOFF : `RMSC_XON;
    end
  end

  // register writes
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sleep_selection <= `RMSC_SEL_RST;
      radio_rate_setting <= 1'b1;
      pin_wake_enable <= 1'b0;
      software_flow_setting <= 1'b0;
      packetization_threshold <= `RMSC_THR_RST;
      max_packet_size <= `RMSC_MAXPK_RST;
      packetization_timeout <= `RMSC_PTO_RST;
      inactivity_wake_time <= `RMSC_WAKE_RST;
      network_identifier <= `RMSC_ID_RST;
      channel <= `RMSC_CHAN_RST;
      dest_address <= `RMSC_DADDR_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `RMSC_REG_CTRL:
        begin
          sleep_selection <= reg_wdata[3:0];
          radio_rate_setting <= reg_wdata[4];
          pin_wake_enable <= reg_wdata[5];
          software_flow_setting <= reg_wdata[6];
        end
        `RMSC_REG_PKT:
        begin
          packetization_threshold <= reg_wdata[7:0];
          max_packet_size <= reg_wdata[23:16];
        end
        `RMSC_REG_TIME:
        begin
          packetization_timeout <= reg_wdata[15:0];
          inactivity_wake_time <= reg_wdata[31:16];
        end
        `RMSC_REG_NET:
        begin
          network_identifier <= reg_wdata[15:0];
          channel <= reg_wdata[23:16];
        end
        `RMSC_REG_ADDR:
          dest_address <= reg_wdata[15:0];
        default:
          ;
      endcase
    end
  end

  // register reads, data valid the cycle after the strobe only
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 32'h0000_0000;
    else if (!reg_rd)
      reg_rdata <= 32'h0000_0000;
    else
    begin
      case (reg_addr)
        `RMSC_REG_CTRL:
          reg_rdata <= {25'h0, software_flow_setting, pin_wake_enable,
                        radio_rate_setting, sleep_selection};
        `RMSC_REG_PKT:
          reg_rdata <= {8'h00, max_packet_size, 8'h00,
                        packetization_threshold};
        `RMSC_REG_TIME:
          reg_rdata <= {inactivity_wake_time, packetization_timeout};
        `RMSC_REG_NET:
          reg_rdata <= {8'h00, channel, network_identifier};
        `RMSC_REG_ADDR:
          reg_rdata <= {16'h0000, dest_address};
        `RMSC_REG_STAT:
          reg_rdata <= {6'h00, 16'(pend), transmit_power_indicator, cts_n,
                        listening, flow_stop, state};
        default:
          reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  a_tx_waits_rx: assert property (
    state == ST_IDLE && rf_rx_busy |=> state != ST_INIT)
    else $error("transmit entered during reception");
  a_thresh_start: assert property (
    state == ST_IDLE && !rx_start && !cmd_seq_det &&
    packetization_threshold != 8'h00 &&
    32'(pend) >= 32'(packetization_threshold) |=> state == ST_INIT)
    else $error("threshold reached without transmit");
  a_init_first: assert property (
    $rose(state == ST_TXPK) |-> $past(state) == ST_INIT)
    else $error("payload without initializer");
  a_pkt_cap: assert property (
    pkt_start |-> pkt_len != 8'h00 && pkt_len <= maxpk_eff)
    else $error("packet length out of range");
  a_rx_filter: assert property (
    rf_pkt_valid && !match |=> !rx_forward)
    else $error("mismatched packet forwarded");
  a_sel_zero: assert property (
    state == ST_IDLE && sleep_selection == 4'h0 |=> state != ST_SLEEP)
    else $error("sleep with zero selection");
  a_pin_wake: assert property (
    state == ST_SLEEP && pin_mode && !pin_lvl |=> state == ST_IDLE)
    else $error("pin low did not wake");
  a_pin_finish: assert property (
    state == ST_TXPK && pin_lvl |=> state != ST_SLEEP)
    else $error("transfer cut by pin sleep");
  a_sleep_pins: assert property (
    state == ST_SLEEP ##1 state == ST_SLEEP |->
    cts_n && !transmit_power_indicator)
    else $error("pins wrong while asleep");
  a_xoff_char: assert property (
    $rose(flow_stop) && software_flow_setting |=>
    flow_char_valid && flow_char == `RMSC_XOFF)
    else $error("stop character missing");

  c_tx_path: cover property (state == ST_INIT ##[1:50] pkt_start);
  c_rx_fwd: cover property (rx_forward);
  c_cyc_wake: cover property (state == ST_SLEEP && cyclic ##1
                              state == ST_IDLE && listening);
  c_pin_sleep: cover property (pin_mode && state == ST_SLEEP);

endmodule // rmsc_ctrl

/* File: verification/rmsc_host_model.sv */
`timescale 1ns/100ps

// host stand-in: paced uart bytes under clear-to-send, sleep pin
module rmsc_host_model
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // bench commands
  input wire logic [7:0] burst_len,
  input wire logic burst_go,
  input wire logic [1:0] gap,
  input wire logic sleep_req,
  // device pins
  input wire logic cts_n,
  output logic ser_byte_valid,
  output logic sleep_pin
);
  logic [7:0] left;
  logic [7:0] sent;
  logic [1:0] pace;

  // one byte per gap; a held-off host keeps the rest for later
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      left <= 8'h00;
      sent <= 8'h00;
      pace <= 2'h0;
      ser_byte_valid <= 1'b0;
      sleep_pin <= 1'b0;
    end
    else
    begin
      ser_byte_valid <= 1'b0;
      if (burst_go)
      begin
        left <= burst_len;
        sent <= 8'h00;
      end
      else if (pace != 2'h0)
        pace <= pace - 2'h1;
      else if (left != 8'h00 && !cts_n)
      begin
        ser_byte_valid <= 1'b1;
        left <= left - 8'h01;
        sent <= sent + 8'h01;
        pace <= gap;
      end
      // raise once a burst has two bytes out or none are left
      if (!sleep_req)
        sleep_pin <= 1'b0;
      else if (left == 8'h00 || sent >= 8'h02)
        sleep_pin <= 1'b1;
    end
  end
endmodule // rmsc_host_model

/* File: verification/radio_mode_sleep_controller_tb.sv */
`timescale 1ns/100ps
`include "rmsc_cfg.svh"

module radio_mode_sleep_controller_tb;
  import rmsc_pkg::*;
  localparam int MS = 2;
  localparam int SLACK = 8;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic init_done = 1'b0;
  logic pkt_near_end = 1'b0;
  logic rf_rx_busy = 1'b0;
  logic rf_init_detect = 1'b0;
  logic rf_pkt_valid = 1'b0;
  logic [15:0] rf_pkt_id = 16'h0;
  logic [7:0] rf_pkt_chan = 8'h0;
  logic [15:0] rf_pkt_addr = 16'h0;
  logic cmd_seq_det = 1'b0;
  logic spi_in_use = 1'b0;
  logic cmd_exit = 1'b0;
  logic [7:0] burst_len = 8'h0;
  logic burst_go = 1'b0;
  logic [1:0] gap = 2'h0;
  logic sleep_req = 1'b0;
  logic [31:0] reg_rdata;
  logic ser_byte_valid, init_start, pkt_start, rx_forward, sleep_pin;
  logic cts_n, transmit_power_indicator, flow_char_valid;
  logic [7:0] pkt_len, flow_char;
  logic [31:0] d, bad;
  logic [7:0] lens[$];
  logic [7:0] flows[$];
  integer seed;
  int fails = 0;
  int tests_run = 0;
  int n_init = 0;
  int n_fwd = 0;
  int icnt = 0;
  int pcnt = 0;
  int n, k;

  rmsc_ctrl #(.DEPTH(64), .MS_CYCLES(MS)) dut
  (
    .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ser_byte_valid(ser_byte_valid),
    .init_start(init_start), .init_done(init_done),
    .pkt_start(pkt_start), .pkt_len(pkt_len),
    .pkt_near_end(pkt_near_end), .rf_rx_busy(rf_rx_busy),
    .rf_init_detect(rf_init_detect), .rf_pkt_valid(rf_pkt_valid),
    .rf_pkt_id(rf_pkt_id), .rf_pkt_chan(rf_pkt_chan),
    .rf_pkt_addr(rf_pkt_addr), .rx_forward(rx_forward),
    .cmd_seq_det(cmd_seq_det), .spi_in_use(spi_in_use),
    .cmd_exit(cmd_exit), .sleep_pin(sleep_pin), .cts_n(cts_n),
    .transmit_power_indicator(transmit_power_indicator),
    .flow_char_valid(flow_char_valid), .flow_char(flow_char)
  );

  rmsc_host_model host
  (
    .sys_clk(sys_clk), .arst_n(arst_n), .burst_len(burst_len),
    .burst_go(burst_go), .gap(gap), .sleep_req(sleep_req),
    .cts_n(cts_n), .ser_byte_valid(ser_byte_valid),
    .sleep_pin(sleep_pin)
  );

  always #2.5 sys_clk = ~sys_clk;

  // radio stand-in acks after short delays and logs what the block sent
  always @(posedge sys_clk)
  begin
    init_done <= (icnt == 1);
    pkt_near_end <= (pcnt == 1);
    icnt <= (init_start === 1'b1) ? 3 : (icnt > 0 ? icnt - 1 : 0);
    pcnt <= (pkt_start === 1'b1) ? 5 : (pcnt > 0 ? pcnt - 1 : 0);
    if (init_start === 1'b1)
      n_init++;
    if (pkt_start === 1'b1)
      lens.push_back(pkt_len);
    if (rx_forward === 1'b1)
      n_fwd++;
    if (flow_char_valid === 1'b1)
      flows.push_back(flow_char);
  end

  // expected spans in clock cycles
  function automatic int sleep_cyc(input int sel);
    return (`RMSC_CYC_BASE_MS << (sel - 4)) * MS;
  endfunction

  function automatic int listen_cyc(input int rate);
    return (rate == 1 ? `RMSC_LISTEN_R1_MS : `RMSC_LISTEN_R0_MS) * MS;
  endfunction

  function automatic logic [31:0] near(input int got, input int exp);
    return {31'h0, (got >= exp - SLACK) && (got <= exp + SLACK)};
  endfunction

  function automatic logic [31:0] len_sum();
    int s;
    s = 0;
    foreach (lens[i]) s += lens[i];
    return s;
  endfunction

  function automatic logic [31:0] len_ok(input int cap);
    len_ok = 32'h1;
    foreach (lens[i]) if ((lens[i] <= cap) !== 1'b1) len_ok = 32'h0;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk);
  endtask

  task automatic send(input int cnt, input int g);
    @(posedge sys_clk);
    burst_len <= cnt[7:0];
    gap <= g[1:0];
    burst_go <= 1'b1;
    @(posedge sys_clk);
    burst_go <= 1'b0;
  endtask

  // counts edges while the power indicator keeps level v
  task automatic hold(input logic v, input int lim, output int c);
    c = 0;
    @(posedge sys_clk);
    #1;
    while (transmit_power_indicator === v && c < lim)
    begin
      @(posedge sys_clk);
      #1;
      c++;
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // the run needs about 70000 cycles, mostly cyclic sleep
  initial
  begin
    #(90000 * 5);
    fails++;
    $display("ERROR watchdog expected finish seen timeout");
    test_done;
  end

  initial
  begin
    seed = 32'h6b9e8b7c;
    cyc(2);
    arst_n <= 1'b1;
    rd(`RMSC_REG_CTRL, d);
    chk("ctrl reset", {28'h1, `RMSC_SEL_RST}, d);
    rd(`RMSC_REG_PKT, d);
    chk("pkt reset", {8'h0, `RMSC_MAXPK_RST, 8'h0, `RMSC_THR_RST}, d);
    rd(`RMSC_REG_TIME, d);
    chk("time reset", {`RMSC_WAKE_RST, `RMSC_PTO_RST}, d);
    rd(`RMSC_REG_STAT, d);
    chk("idle state", {26'h0, ST_IDLE}, d & 32'h3F);
    rd(8'h20, d);
    chk("unmapped read", 32'h0, d);
    // escape only counts while the spi port is free
    for (int s = 1; s >= 0; s--)
    begin
      @(posedge sys_clk);
      spi_in_use <= s[0];
      cmd_seq_det <= 1'b1;
      @(posedge sys_clk);
      cmd_seq_det <= 1'b0;
      rd(`RMSC_REG_STAT, d);
      chk("escape state", s ? ST_IDLE : ST_CMD, d & 32'h3F);
    end
    @(posedge sys_clk);
    cmd_exit <= 1'b1;
    @(posedge sys_clk);
    cmd_exit <= 1'b0;
    // threshold of three; late bytes join the first packet
    wr(`RMSC_REG_TIME, {`RMSC_WAKE_RST, 16'h0000});
    wr(`RMSC_REG_PKT, 32'h0040_0003);
    n_init = 0;
    lens.delete();
    send(2, 0);
    cyc(40);
    chk("below threshold", 0, n_init);
    send(3, 0);
    cyc(40);
    chk("threshold start", 1, n_init);
    chk("init then packet", 5, lens[0]);
    // silence trigger only, packets capped at four bytes
    wr(`RMSC_REG_PKT, 32'h0004_0000);
    wr(`RMSC_REG_TIME, {`RMSC_WAKE_RST, 16'h0004});
    for (int i = 0; i < 3; i++)
    begin
      n = 5 + ($unsigned($random(seed)) % 8);
      lens.delete();
      send(n, $unsigned($random(seed)) % 3);
      cyc(250);
      chk("bytes sent", n, len_sum());
      chk("packet cap", 1, len_ok(4));
    end
    // reception blocks transmit; only full matches are forwarded
    wr(`RMSC_REG_PKT, 32'h0040_0001);
    wr(`RMSC_REG_NET, 32'h002A_1234);
    wr(`RMSC_REG_ADDR, 32'h0000_5678);
    rf_rx_busy <= 1'b1;
    n_init = 0;
    n_fwd = 0;
    send(1, 0);
    for (int i = 0; i < 8; i++)
    begin
      k = i % 4;
      bad = $random(seed) | 32'h1;
      @(posedge sys_clk);
      rf_pkt_id <= (k == 1) ? 16'h1234 ^ bad[15:0] : 16'h1234;
      rf_pkt_chan <= (k == 2) ? 8'h2A ^ bad[7:0] : 8'h2A;
      rf_pkt_addr <= (k == 3) ? 16'h5678 ^ bad[15:0] : 16'h5678;
      rf_pkt_valid <= 1'b1;
      @(posedge sys_clk);
      rf_pkt_valid <= 1'b0;
      cyc(2);
      chk("forward count", i / 4 + 1, n_fwd);
    end
    chk("no tx in rx", 0, n_init);
    rf_rx_busy <= 1'b0;
    cyc(40);
    chk("tx after rx", 1, n_init);
    chk("no flow chars", 0, flows.size());
    // fill with both triggers off, then drain with xon/xoff active
    wr(`RMSC_REG_CTRL, 32'h0000_0050);
    wr(`RMSC_REG_PKT, 32'h001E_0000);
    wr(`RMSC_REG_TIME, {`RMSC_WAKE_RST, 16'h0000});
    n_init = 0;
    send(70, 0);
    cyc(100);
    chk("both triggers off", 0, n_init);
    chk("full cts", 1, cts_n);
    chk("stop char", `RMSC_XOFF, flows[0]);
    wr(`RMSC_REG_PKT, 32'h001E_0001);
    cyc(400);
    chk("cts back", 0, cts_n);
    chk("resume char", `RMSC_XON, flows[1]);
    // pin ignored, then pin sleep waits for the reception to end
    wr(`RMSC_REG_CTRL, 32'h0000_0010);
    sleep_req <= 1'b1;
    cyc(20);
    chk("pin ignored", 1, transmit_power_indicator);
    rf_rx_busy <= 1'b1;
    wr(`RMSC_REG_CTRL, 32'h0000_0011);
    cyc(20);
    chk("rx finishes", 1, transmit_power_indicator);
    rf_rx_busy <= 1'b0;
    cyc(20);
    chk("pin sleep cts", 1, cts_n);
    chk("pin sleep power", 0, transmit_power_indicator);
    rf_rx_busy <= 1'b1;
    rd(`RMSC_REG_STAT, d);
    chk("no rx asleep", {26'h0, ST_SLEEP}, d & 32'h3F);
    rf_rx_busy <= 1'b0;
    sleep_req <= 1'b0;
    cyc(20);
    chk("pin awake", 1, transmit_power_indicator);
    // every cyclic setting: pin wake, inactivity, sleep, listen
    wr(`RMSC_REG_TIME, 32'h000A_0000);
    for (int s = 8; s >= 4; s--)
    begin
      wr(`RMSC_REG_CTRL, {26'h0, 1'b1, s[0], s[3:0]});
      sleep_req <= 1'b1;
      cyc(10);
      sleep_req <= 1'b0;
      hold(1'b0, 40, n);
      chk("pin wake", 1, transmit_power_indicator);
      hold(1'b1, 200, n);
      chk("active span", 1, {31'h0, n <= 10 * MS + SLACK});
      chk("cyclic cts", 1, cts_n);
      hold(1'b0, 40000, n);
      chk("sleep span", 1, near(n, sleep_cyc(s)));
      chk("listen cts", 0, cts_n);
      hold(1'b1, 1000, n);
      chk("listen span", 1, near(n, listen_cyc(s % 2)));
    end
    // initializer outlasts a whole sleep interval, so the wake catches it
    rf_init_detect <= 1'b1;
    hold(1'b0, 5000, n);
    chk("initializer asleep", 1, near(n, sleep_cyc(4)));
    rf_rx_busy <= 1'b1;
    hold(1'b1, 600, n);
    chk("stay for initializer", 600, n);
    rf_init_detect <= 1'b0;
    rf_rx_busy <= 1'b0;
    hold(1'b1, 200, n);
    chk("sleep after rx", 1, near(n, 10 * MS));
    test_done;
  end
endmodule // radio_mode_sleep_controller_tb
